//--- sbs_cfg.svh
// Constants for the halt and subtract-with-borrow execution block
// What this block does
// - Halt clears the power-down flag and sets the time-out flag, unless a watchdog time-out falls in the same cycle.
// - Halt zeroes the watchdog counter and clears its postscaler.
// - After decode, halt enters low power with the oscillator stopped until wake-up.
// - A watchdog time-out wake-up clears the time-out flag.
// - Subtract computes accumulator minus file register minus inverted carry, two's complement.
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_OP_SLEEP      16'h0003
`define SBS_OP_SUB_HI     6'h15
`define SBS_OP_HI_MSB     15
`define SBS_OP_HI_LSB     10
`define SBS_DEST_BIT      9
`define SBS_BANK_BIT      8
`define SBS_W_RST         8'h00
`define SBS_WDT_CLR       8'h00
`define SBS_FLAG_N_RST    1'b1
`define SBS_STAT_RST      1'b0
`define SBS_WDT_CNT_W     8
`define SBS_WDT_PS_W      7
`endif

//--- sbs_pkg.sv
// Types for the halt and subtract-with-borrow execution block
package sbs_pkg;
  typedef enum logic [2:0] {
    SBS_IDLE  = 3'b000,
    SBS_Q1    = 3'b001,
    SBS_Q2    = 3'b011,
    SBS_Q3    = 3'b010,
    SBS_Q4    = 3'b110,
    SBS_SLEEP = 3'b111
  } sbs_state_t;
  typedef logic [7:0] sbs_byte_t;
endpackage

//--- sbs_wdt_if.sv
// Watchdog control carrier between the core logic and the watchdog
`timescale 1ns/1ps
interface sbs_wdt_if;
  logic       clr;
  logic       timeout;
  logic [7:0] count;
  modport ctl (output clr, input timeout, input count);
  modport wdt (input clr, output timeout, output count);
endinterface

//--- sbs_wdt.sv
// Watchdog counter with postscaler
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_wdt
  import sbs_pkg::*;
#(
  parameter int PS_W = `SBS_WDT_PS_W
)(
  input wire logic ref_clk,  // Core clock
  input wire logic arst_n,   // Async reset, active low
  input wire logic wdt_en,   // Watchdog enable
  sbs_wdt_if.wdt   bus       // Clear in, count and time-out out
);
  logic [PS_W-1:0] ps_q;
  logic [7:0]      cnt_q;
  logic            to_q;
  logic            ps_wrap;

  assign ps_wrap     = wdt_en && (ps_q == {PS_W{1'b1}});
  assign bus.count   = cnt_q;
  assign bus.timeout = to_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ps_q  <= '0;
      cnt_q <= `SBS_WDT_CLR;
    end
    else if (bus.clr)
    begin
      ps_q  <= '0;
      cnt_q <= `SBS_WDT_CLR;
    end
    else if (wdt_en)
    begin
      ps_q <= ps_q + 1'b1;
      if (ps_wrap)
        cnt_q <= cnt_q + 8'h01;
    end
  end

  // One-cycle time-out pulse when the counter rolls over
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      to_q <= 1'b0;
    else
      to_q <= !bus.clr && ps_wrap && (cnt_q == 8'hFF);
  end
endmodule // sbs_wdt

//--- sbs_core.sv
// Halt and subtract-with-borrow execution logic
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module sbs_core
  import sbs_pkg::*;
(
  input  wire logic        ref_clk,         // Core clock, 125 MHz
  input  wire logic        arst_n,          // Async reset, active low
  input  wire logic        instr_valid,     // Instruction word offered
  input  wire logic [15:0] instr_word,      // Instruction word
  output logic             instr_ready,     // Ready to take a word
  output logic             done,            // Instruction retired pulse
  output logic [7:0]       freg_addr,       // File register address
  output logic             freg_bank_sel,   // Bank select bit
  output logic             freg_rd,         // File read strobe
  input  wire logic [7:0]  freg_rdata,      // File read data
  output logic             freg_wr,         // File write strobe
  output logic [7:0]       freg_wdata,      // File write data
  output logic [7:0]       accum,           // Working accumulator
  output logic             flag_n,          // Negative flag
  output logic             flag_ov,         // Overflow flag
  output logic             flag_z,          // Zero flag
  output logic             flag_dc,         // Digit carry flag
  output logic             flag_c,          // Carry flag
  output logic             time_out_flag_n, // Time-out flag, active low
  output logic             power_down_flag_n, // Power-down flag, active low
  output logic             osc_en,          // Oscillator run
  output logic             asleep,          // Low-power state
  input  wire logic        wdt_en,          // Watchdog enable
  output logic [7:0]       watchdog_counter, // Watchdog count
  input  wire logic        wake_pin         // External wake-up source
);
  sbs_state_t state_q;
  sbs_state_t state_d;
  sbs_byte_t  w_q;
  sbs_byte_t  fval_q;
  sbs_byte_t  res_q;
  logic [15:0] ir_q;
  logic       n_q, ov_q, z_q, dc_q, c_q;
  logic       to_n_q, pwr_dn_n_q;
  logic       done_q, rd_q, wr_q;
  logic [2:0] wake_s_q;
  logic       wake_lvl_q;
  logic       is_sleep, is_sub, dest_f, wdt_clr;
  logic [8:0] sum9;
  logic [4:0] sum5;

  sbs_wdt_if wdt_bus ();

  sbs_wdt u_wdt (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wdt_en  (wdt_en),
    .bus     (wdt_bus)
  );

  assign is_sleep = (ir_q == `SBS_OP_SLEEP);
  assign is_sub   = (ir_q[`SBS_OP_HI_MSB:`SBS_OP_HI_LSB] == `SBS_OP_SUB_HI);
  assign dest_f   = ir_q[`SBS_DEST_BIT];
  // W - f - !C equals W + ~f + C
  assign sum9     = {1'b0, w_q} + {1'b0, ~fval_q} + {8'h00, c_q};
  assign sum5     = {1'b0, w_q[3:0]} + {1'b0, ~fval_q[3:0]} + {4'h0, c_q};
  assign wdt_clr  = (state_q == SBS_Q4) && is_sleep;
  assign wdt_bus.clr = wdt_clr;

  assign instr_ready      = (state_q == SBS_IDLE);
  assign done             = done_q;
  assign freg_addr        = ir_q[7:0];
  assign freg_bank_sel    = ir_q[`SBS_BANK_BIT];
  assign freg_rd          = rd_q;
  assign freg_wr          = wr_q;
  assign freg_wdata       = res_q;
  assign accum            = w_q;
  assign flag_n           = n_q;
  assign flag_ov          = ov_q;
  assign flag_z           = z_q;
  assign flag_dc          = dc_q;
  assign flag_c           = c_q;
  assign time_out_flag_n  = to_n_q;
  assign power_down_flag_n = pwr_dn_n_q;
  assign asleep           = (state_q == SBS_SLEEP);
  assign osc_en           = (state_q != SBS_SLEEP);
  assign watchdog_counter = wdt_bus.count;

  // Wake pin synchroniser, level taken when stages two and three agree
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wake_s_q   <= 3'b000;
      wake_lvl_q <= 1'b0;
    end
    else
    begin
      wake_s_q <= {wake_s_q[1:0], wake_pin};
      if (wake_s_q[1] == wake_s_q[2])
        wake_lvl_q <= wake_s_q[2];
    end
  end

  // Quarter-phase sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SBS_IDLE:  if (instr_valid) state_d = SBS_Q1;
      SBS_Q1:    state_d = SBS_Q2;
      SBS_Q2:    state_d = SBS_Q3;
      SBS_Q3:    state_d = SBS_Q4;
      SBS_Q4:    state_d = is_sleep ? SBS_SLEEP : SBS_IDLE;
      SBS_SLEEP: if (wdt_bus.timeout || wake_lvl_q) state_d = SBS_IDLE;
      default:   state_d = SBS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= SBS_IDLE;
    else
      state_q <= state_d;
  end

  // Instruction capture
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ir_q <= 16'h0000;
    else if (instr_ready && instr_valid)
      ir_q <= instr_word;
  end

  // File read in Q2, operand captured in Q3
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q   <= 1'b0;
      fval_q <= 8'h00;
    end
    else
    begin
      rd_q <= (state_d == SBS_Q2) && is_sub;
      if (rd_q)
        fval_q <= freg_rdata;
    end
  end

  // Q4 write-back of the result
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      w_q   <= `SBS_W_RST;
      res_q <= 8'h00;
      wr_q  <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      if (state_q == SBS_Q3 && is_sub)
      begin
        res_q <= sum9[7:0];
        if (dest_f)
          wr_q <= 1'b1;
        else
          w_q <= sum9[7:0];
      end
    end
  end

  // Arithmetic flags, loaded together with the result
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      n_q  <= `SBS_STAT_RST;
      ov_q <= `SBS_STAT_RST;
      z_q  <= `SBS_STAT_RST;
      dc_q <= `SBS_STAT_RST;
      c_q  <= `SBS_STAT_RST;
    end
    else if (state_q == SBS_Q3 && is_sub)
    begin
      n_q  <= sum9[7];
      z_q  <= (sum9[7:0] == 8'h00);
      c_q  <= sum9[8];
      dc_q <= sum5[4];
      ov_q <= (w_q[7] != fval_q[7]) && (sum9[7] != w_q[7]);
    end
  end

  // Time-out flag; a time-out in the same cycle wins over halt
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      to_n_q <= `SBS_FLAG_N_RST;
    else if (wdt_bus.timeout)
      to_n_q <= 1'b0;
    else if (wdt_clr)
      to_n_q <= 1'b1;
  end

  // Power-down flag, cleared by halt, set again only by reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pwr_dn_n_q <= `SBS_FLAG_N_RST;
    else if (wdt_clr)
      pwr_dn_n_q <= 1'b0;
  end

  // Retire pulse
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      done_q <= 1'b0;
    else
      done_q <= (state_q == SBS_Q4);
  end
endmodule // sbs_core

//--- sbs_core_checker.sv
// Port-level assertions for the halt and subtract block
`timescale 1ns/1ps
module sbs_chk (
  input wire logic       ref_clk,           // Clock
  input wire logic       arst_n,            // Reset
  input wire logic       instr_valid,       // Offer
  input wire logic       instr_ready,       // Ready
  input wire logic       done,              // Retired
  input wire logic       freg_rd,           // Read
  input wire logic       freg_wr,           // Write
  input wire logic       time_out_flag_n,   // Time-out
  input wire logic       power_down_flag_n, // Power-down
  input wire logic       osc_en,            // Osc run
  input wire logic       asleep,            // Low power
  input wire logic       wdt_en,            // Wdt on
  input wire logic [7:0] watchdog_counter   // Count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_halt_pd_low: assert property ($rose(asleep) |-> !power_down_flag_n)
    else $error("power-down flag not cleared by halt");
  a_halt_to_set: assert property ($rose(asleep) && !wdt_en |-> time_out_flag_n)
    else $error("time-out flag not set by halt");
  a_halt_wdt_zero: assert property ($rose(asleep) |-> watchdog_counter == 8'h00)
    else $error("watchdog not cleared by halt");
  a_osc_stopped: assert property (osc_en != asleep)
    else $error("oscillator state wrong");
  a_sleep_at_retire: assert property ($rose(asleep) |-> done)
    else $error("low power entered outside halt retirement");
  a_sleep_no_exec: assert property (asleep |-> !instr_ready && !freg_rd && !freg_wr)
    else $error("activity while asleep");
  a_to_wake_cause: assert property ($fell(time_out_flag_n) |-> ##[0:1] !asleep)
    else $error("time-out flag cleared without wake");
  a_read_to_done: assert property (freg_rd |-> ##3 done)
    else $error("read phase misplaced");
  a_write_to_done: assert property (freg_wr |=> done)
    else $error("write phase misplaced");
  a_take_to_done: assert property (instr_valid && instr_ready |-> ##5 done)
    else $error("instruction not retired in time");
  c_write: cover property (freg_wr);
  c_halt_wdt: cover property ($rose(asleep) && wdt_en);
  c_timeout: cover property ($fell(time_out_flag_n));
endmodule // sbs_chk
bind sbs_core sbs_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .done(done), .freg_rd(freg_rd), .freg_wr(freg_wr),
  .time_out_flag_n(time_out_flag_n), .power_down_flag_n(power_down_flag_n),
  .osc_en(osc_en), .asleep(asleep), .wdt_en(wdt_en), .watchdog_counter(watchdog_counter));

//--- tb.sv
// Self-checking bench for the halt and subtract block
`timescale 1ns/1ps
`include "sbs_cfg.svh"
module tb;
  logic ref_clk, arst_n, instr_valid, wdt_en, wake_pin, instr_ready, done, bank, rd, wr;
  logic n_f, ov_f, z_f, dc_f, c_f, to_n, pwr_dn_n, osc_en, asleep, wr_hit, rd_hit;
  logic [15:0] instr_word;
  logic [7:0] rdata, addr, wdata, accum, wdt_cnt, wd_seen;
  int bad_count, comparisons, seed, w, c, f, d, a, r, nf, i, n;
  sbs_core i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .done(done), .freg_addr(addr),
    .freg_bank_sel(bank), .freg_rd(rd), .freg_rdata(rdata), .freg_wr(wr), .freg_wdata(wdata),
    .accum(accum), .flag_n(n_f), .flag_ov(ov_f), .flag_z(z_f), .flag_dc(dc_f), .flag_c(c_f),
    .time_out_flag_n(to_n), .power_down_flag_n(pwr_dn_n), .osc_en(osc_en), .asleep(asleep),
    .wdt_en(wdt_en), .watchdog_counter(wdt_cnt), .wake_pin(wake_pin));
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Offer one word, then wait for retirement, noting any file write
  task issue(logic [15:0] wd);
    instr_valid = 1;
    instr_word = wd;
    wr_hit = 0;
    rd_hit = 0;
    @(posedge ref_clk);
    #1 instr_valid = 0;
    instr_word = ~wd;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1 n++;
      if (rd === 1'b1)
        rd_hit = 1;
      if (wr === 1'b1)
      begin
        wr_hit = 1;
        wd_seen = wdata;
      end
    end
  endtask
  task wake_wait(int lim);
    n = 0;
    while (asleep !== 1'b0 && n < lim)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    #400000 bad_count++;
    complete_run;
  end
  initial
  begin
    seed = 94;
    arst_n = 0;
    instr_valid = 0;
    instr_word = 0;
    rdata = 0;
    wdt_en = 0;
    wake_pin = 0;
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1;
    chk("reset", {to_n, pwr_dn_n, osc_en, asleep, instr_ready}, 5'h1d);
    w = 0;
    c = 0;
    for (i = 0; i < 16; i++)
    begin
      f = $random(seed) & 255;
      d = $random(seed) & 1;
      a = $random(seed) & 511;
      rdata = f;
      nf = ~f & 255;
      r = w + nf + c;
      issue({`SBS_OP_SUB_HI, d[0], a[8:0]});
      chk("dest", d ? wd_seen : accum, r[7:0]);
      chk("accum", accum, d ? w[7:0] : r[7:0]);
      chk("wrote", wr_hit, d[0]);
      chk("addr", addr, a[7:0]);
      chk("bank", bank, a[8]);
      chk("read", rd_hit, 1'b1);
      chk("flags", {n_f, ov_f, z_f, dc_f, c_f}, {r[7], ((w ^ r) & (nf ^ r) & 128) != 0,
        r[7:0] == 0, ((w & 15) + (nf & 15) + c) > 15, r[8]});
      if (d == 0) w = r & 255;
      c = r[8];
      rdata = ~rdata;
    end
    issue(`SBS_OP_SLEEP);
    chk("halt flags", {pwr_dn_n, to_n}, 8'h01);
    chk("osc", {osc_en, asleep}, 8'h01);
    instr_valid = 1;
    instr_word = {`SBS_OP_SUB_HI, 10'h0_3ff};
    repeat (20) @(posedge ref_clk);
    #1 instr_valid = 0;
    chk("still asleep", {asleep, accum}, {1'b1, w[7:0]});
    wake_pin = 1;
    wake_wait(20);
    chk("pin wake", asleep, 0);
    wake_pin = 0;
    wdt_en = 1;
    repeat (300) @(posedge ref_clk);
    #1 issue(`SBS_OP_SLEEP);
    chk("wdt cleared", wdt_cnt, 8'h00);
    chk("halt to", to_n, 1);
    wake_wait(40000);
    chk("wdt period", n, (1 << (`SBS_WDT_PS_W + `SBS_WDT_CNT_W)) + 1);
    @(posedge ref_clk);
    #1 chk("wdt wake", {asleep, to_n}, 8'h00);
    issue(`SBS_OP_SLEEP);
    chk("rehalt flags", {pwr_dn_n, to_n}, 8'h01);
    complete_run;
  end
endmodule // tb
